// ### src/sleep_power_map.vh
/*
 * register offsets, field positions, reset values for the sleep power planning block.
 * assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
// Operation
// RULE1 - small sram clock gated off when bit 5 set, running when clear
// RULE2 - main sram clock stopped when bit 4 set, running when clear
// RULE3 - in halt, flash disabled when bit 3 set, else standby; resets to one
// RULE4 - ethernet phy powered down while bit 1 set
// RULE5 - writing arm bit one arms plan for next sleep entry; zero cancels
// RULE6 - hardware clears arm bit once plan has executed
// RULE7 - software writes 0010b into plan bits 14 to 11
// RULE8 - converter bias enable follows bit 10 immediately
// RULE9 - converter enable bit 9 turns converter on, pass-through off, immediately
// RULE10 - main regulator stays on when bit 8 set, off in executed plan otherwise
// RULE11 - system supply kept when bit 7 set, removed in executed plan otherwise
// RULE12 - software writes zero to plan bit 6
// RULE13 - large retention sram gets dual supply in sleep when bit 4 set
// RULE14 - extended domain gets dual supply in sleep when bit 3 set
// RULE15 - core domain gets dual supply in sleep when bit 2 set
// RULE16 - small retention sram gets dual supply in sleep when bit 1 set
// RULE17 - planning bits other than converter controls apply only in sleep or shutdown
// RULE18 - adjust register bits 15 to 8 are read-only, writes ignored
// RULE19 - software preserves adjust bits 5 to 3 when writing
// RULE20 - three-bit trim selects aux regulator output, default 100b
// RULE21 - software sets deep sleep control, plan, wake sources, then waits
// RULE22 - halt stops clock system, peripherals powered; wake restarts clocks then core
// RULE23 - read-only reserved bits return reset values, ignore writes
`ifndef SLEEP_POWER_MAP_VH
`define SLEEP_POWER_MAP_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_PERIPH_SLEEP_POWER 4'h0
`define OFS_SLEEP_POWER_PLAN   4'h4
`define OFS_AUX_LDO_ADJUST     4'h8
`define OFS_MODE_STATUS        4'hc

// ----------------------------------------
// peripheral sleep power control
// ----------------------------------------
`define BIT_SMALL_SRAM_CLOCK_OFF  5
`define BIT_MAIN_SRAM_CLOCK_OFF   4
`define BIT_FLASH_HALT_POWER_DOWN 3
`define BIT_ETHER_PHY_POWER_DOWN  1
`define PERIPH_WRITE_MASK         8'h3a
`define PERIPH_RESET              8'h08

// ----------------------------------------
// sleep power plan
// ----------------------------------------
`define BIT_POWER_PLAN_ARM        15
`define BIT_CONVERTER_BIAS        10
`define BIT_CONVERTER_ENABLE      9
`define BIT_MAIN_REGULATOR_PLAN   8
`define BIT_SYSTEM_SUPPLY_PLAN    7
`define BIT_LARGE_RETENTION_PLAN  4
`define BIT_EXTENDED_DOMAIN_PLAN  3
`define BIT_CORE_DOMAIN_PLAN      2
`define BIT_SMALL_RETENTION_PLAN  1
`define PLAN_WRITE_MASK           16'hffde
`define PLAN_RESET                16'h01df

// ----------------------------------------
// aux regulator adjust
// ----------------------------------------
`define ADJ_WRITE_MASK            16'h003f
`define ADJ_RESET                 16'h0024
`define ADJ_HIGH_READ             8'h00
`define ADJ_STORED_RESET          6'h24
`define TRIM_RESET                3'h4

// ----------------------------------------
// mode status bits
// ----------------------------------------
`define BIT_STAT_HALT             0
`define BIT_STAT_SLEEP            1
`define BIT_STAT_SHUTDOWN         2
`define BIT_STAT_PLAN_APPLIED     3

`endif

// ### src/sleep_power_planning_control.v
/*
 * sleep power planning control: peripheral sleep power, plan register, aux regulator trim.
 * assumes the core's power state machine reports halt/sleep/shutdown entry and wake.
 */
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "sleep_power_map.vh"

module sleep_power_planning_control (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// low-power mode requests from the core (same clock)
	input  wire        halt_request,
	input  wire        sleep_request,
	input  wire        shutdown_request,
	input  wire        wake_event,
	// immediate peripheral controls
	output reg         small_sram_clock_off,
	output reg         main_sram_clock_off,
	output reg         ether_phy_power_down,
	output reg         converter_bias_enable,
	output reg         converter_enable,
	output reg         pass_through_enable,
	// halt mode controls
	output reg         clock_system_stop,
	output reg         core_run_enable,
	output reg         flash_disable,
	output reg         flash_standby,
	// applied sleep power plan and aux regulator trim
	output reg         main_regulator_on,
	output reg         switched_supply_output,
	output reg         large_retention_sram_aux,
	output reg         extended_domain_aux,
	output reg         core_domain_aux,
	output reg         small_retention_sram_aux,
	output reg  [2:0]  aux_regulator_trim
);

	// ----------------------------------------
	// mode sequencer states
	// ----------------------------------------
	localparam [4:0] ST_RUN      = 5'h01;
	localparam [4:0] ST_HALT     = 5'h02;
	localparam [4:0] ST_LOWPOWER = 5'h04;
	localparam [4:0] ST_CLK_UP   = 5'h08;
	localparam [4:0] ST_REG_UP   = 5'h10;

	reg  [7:0]  periph_q;
	reg  [15:0] plan_q;
	reg  [5:0]  adj_q;
	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg         plan_live_q;
	reg         shutdown_q;
	reg         plan_applied_q;

	reg  [31:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_full_q;
	reg         w_full_q;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [15:0] merge16;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0]  strb;
		input [15:0] mask;
		reg   [15:0] lane;
		begin
			lane    = {{8{strb[1]}}, {8{strb[0]}}} & mask;
			merge16 = (old_v & ~lane) | (new_v & lane);
		end
	endfunction

	function [1:0] map_hit;
		input [31:0] a;
		begin
			map_hit = (a[31:4] == 28'h0000000) ? 2'b00 : 2'b10;
		end
	endfunction

	// ----------------------------------------
	// axi write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_q && !s_axi_bvalid;

	wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	wire [3:0] wofs = {awaddr_q[3:2], 2'b00};
	wire plan_exec = (state_q == ST_RUN) && plan_q[`BIT_POWER_PLAN_ARM] &&
			(sleep_request || shutdown_request);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			awaddr_q     <= 32'h00000000;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= map_hit(awaddr_q);
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			periph_q <= `PERIPH_RESET;
			plan_q   <= `PLAN_RESET;
			adj_q    <= `ADJ_STORED_RESET;
		end else begin
			if (do_write && map_hit(awaddr_q) == 2'b00) begin
				if (wofs == `OFS_PERIPH_SLEEP_POWER && wstrb_q[0])
					periph_q <= (periph_q & ~`PERIPH_WRITE_MASK) |
						(wdata_q[7:0] & `PERIPH_WRITE_MASK); // RULE23
				if (wofs == `OFS_SLEEP_POWER_PLAN)
					plan_q <= merge16(plan_q, wdata_q[15:0], wstrb_q[1:0],
						`PLAN_WRITE_MASK); // RULE5 RULE23
				if (wofs == `OFS_AUX_LDO_ADJUST && wstrb_q[0])
					adj_q <= wdata_q[5:0]; // RULE18 RULE20
			end
			// execution wins over a simultaneous rewrite of the arm bit
			if (plan_exec)
				plan_q[`BIT_POWER_PLAN_ARM] <= 1'b0; // RULE6
		end
	end

	// ----------------------------------------
	// axi read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= map_hit(s_axi_araddr);
			case ({s_axi_araddr[31:2], 2'b00})
			{28'h0000000, `OFS_PERIPH_SLEEP_POWER}: s_axi_rdata <= {24'h000000, periph_q};
			{28'h0000000, `OFS_SLEEP_POWER_PLAN}:   s_axi_rdata <= {16'h0000, plan_q};
			{28'h0000000, `OFS_AUX_LDO_ADJUST}:
				s_axi_rdata <= {16'h0000, `ADJ_HIGH_READ, 2'b00, adj_q}; // RULE18
			{28'h0000000, `OFS_MODE_STATUS}:
				s_axi_rdata <= {28'h0000000, plan_applied_q, state_q == ST_LOWPOWER &&
					shutdown_q, state_q == ST_LOWPOWER, state_q == ST_HALT};
			default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// mode sequencer
	// ----------------------------------------
	// wake order: regulator and clocks on one edge (ST_REG_UP also lifts clock_system_stop; halt skips ST_REG_UP), then core
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_RUN: begin
			if (sleep_request || shutdown_request)
				state_d = ST_LOWPOWER;
			else if (halt_request)
				state_d = ST_HALT;
		end
		ST_HALT: begin
			if (wake_event)
				state_d = ST_CLK_UP; // RULE22
		end
		ST_LOWPOWER: begin
			if (wake_event)
				state_d = ST_REG_UP;
		end
		ST_REG_UP: state_d = ST_CLK_UP;
		ST_CLK_UP: state_d = ST_RUN;
		default:   state_d = ST_RUN;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q        <= ST_RUN;
			plan_live_q    <= 1'b0;
			shutdown_q     <= 1'b0;
			plan_applied_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (plan_exec) begin
				plan_live_q    <= 1'b1;
				plan_applied_q <= 1'b1;
				shutdown_q     <= shutdown_request;
			end else if (state_q == ST_REG_UP) begin
				plan_live_q <= 1'b0;
			end
			if (state_q == ST_RUN && !plan_exec && (sleep_request || shutdown_request))
				shutdown_q <= shutdown_request;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			small_sram_clock_off     <= 1'b0;
			main_sram_clock_off      <= 1'b0;
			ether_phy_power_down     <= 1'b0;
			converter_bias_enable    <= 1'b0;
			converter_enable         <= 1'b0;
			pass_through_enable      <= 1'b1;
			clock_system_stop        <= 1'b0;
			core_run_enable          <= 1'b1;
			flash_disable            <= 1'b0;
			flash_standby            <= 1'b0;
			main_regulator_on        <= 1'b1;
			switched_supply_output   <= 1'b1;
			large_retention_sram_aux <= 1'b1;
			extended_domain_aux      <= 1'b1;
			core_domain_aux          <= 1'b1;
			small_retention_sram_aux <= 1'b1;
			aux_regulator_trim       <= `TRIM_RESET;
		end else begin
			small_sram_clock_off  <= periph_q[`BIT_SMALL_SRAM_CLOCK_OFF]; // RULE1
			main_sram_clock_off   <= periph_q[`BIT_MAIN_SRAM_CLOCK_OFF]; // RULE2
			ether_phy_power_down  <= periph_q[`BIT_ETHER_PHY_POWER_DOWN]; // RULE4
			converter_bias_enable <= plan_q[`BIT_CONVERTER_BIAS]; // RULE8
			converter_enable      <= plan_q[`BIT_CONVERTER_ENABLE]; // RULE9
			pass_through_enable   <= !plan_q[`BIT_CONVERTER_ENABLE]; // RULE9
			aux_regulator_trim    <= adj_q[2:0]; // RULE20
			clock_system_stop <= (state_q != ST_RUN) && (state_q != ST_CLK_UP) &&
				(state_q != ST_REG_UP); // RULE22
			core_run_enable   <= (state_q == ST_RUN);
			flash_disable <= (state_q == ST_HALT) &&
				periph_q[`BIT_FLASH_HALT_POWER_DOWN]; // RULE3
			flash_standby <= (state_q == ST_HALT) &&
				!periph_q[`BIT_FLASH_HALT_POWER_DOWN]; // RULE3
			// presets only reach the supplies while the executed plan is live
			if (plan_live_q && state_q == ST_LOWPOWER) begin // RULE17
				main_regulator_on        <= plan_q[`BIT_MAIN_REGULATOR_PLAN]; // RULE10
				switched_supply_output   <= plan_q[`BIT_SYSTEM_SUPPLY_PLAN]; // RULE11
				large_retention_sram_aux <= plan_q[`BIT_LARGE_RETENTION_PLAN]; // RULE13
				extended_domain_aux      <= plan_q[`BIT_EXTENDED_DOMAIN_PLAN]; // RULE14
				core_domain_aux          <= plan_q[`BIT_CORE_DOMAIN_PLAN]; // RULE15
				small_retention_sram_aux <= plan_q[`BIT_SMALL_RETENTION_PLAN]; // RULE16
			end else begin
				main_regulator_on        <= 1'b1;
				switched_supply_output   <= 1'b1;
				large_retention_sram_aux <= 1'b1;
				extended_domain_aux      <= 1'b1;
				core_domain_aux          <= 1'b1;
				small_retention_sram_aux <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ### testbench/power_plan_props.sv
/* assertions on the sleep power planning block's ports.
 * assumes one clock, aresetn synchronous active low, bound from the testbench. */
`timescale 1ns/1ns
`default_nettype none
module power_plan_props (
	// clock, reset and bus
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// mode requests
	input wire logic        halt_request,
	input wire logic        sleep_request,
	input wire logic        shutdown_request,
	input wire logic        wake_event,
	// controls
	input wire logic        converter_enable,
	input wire logic        pass_through_enable,
	input wire logic        clock_system_stop,
	input wire logic        core_run_enable,
	input wire logic        flash_disable,
	input wire logic        flash_standby,
	input wire logic        main_regulator_on,
	input wire logic        switched_supply_output,
	input wire logic        large_retention_sram_aux,
	input wire logic        extended_domain_aux,
	input wire logic        core_domain_aux,
	input wire logic        small_retention_sram_aux
);
	wire logic all_sup = main_regulator_on && switched_supply_output && large_retention_sram_aux
		&& extended_domain_aux && core_domain_aux && small_retention_sram_aux;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_low_req;
		core_run_enable && (sleep_request || shutdown_request);
	endsequence
	// both halves land on one edge, the response is launched on the next
	a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid) else $error("no write response");
	a_unmapped_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr >= 32'h10 |-> ##2 s_axi_bresp == 2'h2) else $error("unmapped write not refused");
	a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	a_pass_inverse: assert property (pass_through_enable != converter_enable) else $error("pass-through wrong");
	a_flash_exclusive: assert property (!(flash_disable && flash_standby)) else $error("flash both");
	a_run_supplies: assert property (core_run_enable |-> all_sup) else $error("plan applied in run");
	a_low_stops: assert property (s_low_req |-> ##2 clock_system_stop && !core_run_enable) else $error("no low power");
	a_halt_flash: assert property (core_run_enable && halt_request && !sleep_request && !shutdown_request
		|-> ##2 (flash_disable || flash_standby)) else $error("flash not parked in halt");
	a_wake_resumes: assert property (clock_system_stop && wake_event |-> ##[1:5] core_run_enable) else $error("no wake");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/* self-checking bench for the sleep power planning block.
 * assumes the block's AXI4-Lite timing and mode walk as handed over. */
`timescale 1ns/1ns
`default_nettype none
`define chk(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        halt_request = 1'h0, sleep_request = 1'h0, shutdown_request = 1'h0;
	logic        wake_event = 1'h0, small_sram_clock_off, main_sram_clock_off, ether_phy_power_down;
	logic        converter_bias_enable, converter_enable, pass_through_enable, clock_system_stop;
	logic        core_run_enable, flash_disable, flash_standby, main_regulator_on;
	logic        switched_supply_output, large_retention_sram_aux, extended_domain_aux;
	logic        core_domain_aux, small_retention_sram_aux;
	logic [2:0]  aux_regulator_trim;
	logic [15:0] rnd = 16'h0031, d;
	int          failures = 0, compares = 0, i;
	wire logic [5:0] sup = {main_regulator_on, switched_supply_output, large_retention_sram_aux,
		extended_domain_aux, core_domain_aux, small_retention_sram_aux};

	sleep_power_planning_control u_dut (.*);
	always #50 aclk = ~aclk;

	// ----------------------------------------
	// expectations and bus tasks
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// read-only and reserved bits keep their reset levels
	function automatic logic [15:0] expect_read(input logic [31:0] a, input logic [15:0] v);
		return a == 32'h0 ? (v & 16'h003a) : a == 32'h4 ? ((v & 16'hffde) | 16'h0001) : (v & 16'h003f);
	endfunction
	task close_out;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [31:0] a, input logic [15:0] v);
		int n;
		logic aw_hs, w_hs, b_hs;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, v};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			// settled levels at the falling edge are what the next rising edge sees
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid;
			if (b_hs) rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw_hs) s_axi_awvalid <= 1'h0;
			if (w_hs) s_axi_wvalid <= 1'h0;
			if (b_hs) break;
		end
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
		if (n == 40) begin `chk(1'h0, 1'h1); close_out(); end
	endtask
	task rd_chk(input logic [31:0] a, input logic [15:0] e);
		int n;
		logic ar_hs, r_hs;
		logic [31:0] rdat;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid;
			if (r_hs) rdat = s_axi_rdata;
			@(posedge aclk);
			if (ar_hs) s_axi_arvalid <= 1'h0;
			if (r_hs) break;
		end
		s_axi_rready <= 1'h0;
		if (n == 40) begin `chk(1'h0, 1'h1); close_out(); end
		`chk(rdat, {16'h0, e})
	endtask
	// 0 halt, 1 sleep, 2 shutdown, 3 wake (waits for the core to run again)
	task mode(input int k);
		int n;
		@(posedge aclk);
		case (k)
			0: halt_request <= 1'h1;
			1: sleep_request <= 1'h1;
			2: shutdown_request <= 1'h1;
			default: wake_event <= 1'h1;
		endcase
		@(posedge aclk);
		{halt_request, sleep_request, shutdown_request, wake_event} <= 4'h0;
		for (n = 0; n < 10; n++) begin
			@(posedge aclk);
			#1;
			if (k == 3 && core_run_enable) break;
		end
		if (k == 3 && !core_run_enable) begin `chk(1'h0, 1'h1); close_out(); end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		#1;
		`chk({aux_regulator_trim, pass_through_enable, flash_disable, flash_standby}, 6'h24)
		rd_chk(32'h0, 16'h0008);
		rd_chk(32'h4, 16'h01df);
		rd_chk(32'h8, 16'h0024);
		for (i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			d = i == 5 ? 16'hffff : rnd;
			wr(32'h0, d);
			rd_chk(32'h0, expect_read(32'h0, d));
			`chk({small_sram_clock_off, main_sram_clock_off, ether_phy_power_down}, {d[5:4], d[1]})
		end
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			d = {rnd[15:6], 3'h4, i[2:0]};
			wr(32'h8, d);
			rd_chk(32'h8, expect_read(32'h8, d));
			`chk(aux_regulator_trim, i[2:0])
		end
		wr(32'h10, 16'h0000);
		`chk(rsp, 2'h2)
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			d = {5'h02, rnd[10:7], 1'h0, rnd[5:0]};
			wr(32'h4, d);
			rd_chk(32'h4, expect_read(32'h4, d));
			`chk({converter_bias_enable, converter_enable, sup}, {d[10:9], 6'h3f})
		end
		for (i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			d = {7'h44, rnd[8:7], 2'h0, rnd[4:1], 1'h1};
			wr(32'h4, d);
			rd_chk(32'h4, expect_read(32'h4, d));
			if (i == 2) wr(32'h4, d & 16'h7fff);
			mode(i == 1 ? 2 : 1);
			`chk({clock_system_stop, core_run_enable}, 2'h2)
			rd_chk(32'hc, i == 1 ? 16'h000e : 16'h000a);
			`chk(sup, i == 2 ? 6'h3f : {d[8:7], d[4:1]})
			rd_chk(32'h4, expect_read(32'h4, d & 16'h7fff));
			mode(3);
			`chk(sup, 6'h3f)
		end
		for (i = 0; i < 2; i++) begin
			wr(32'h0, i ? 16'h0008 : 16'h0000);
			mode(0);
			`chk({flash_disable, flash_standby}, i ? 2'h2 : 2'h1)
			`chk({clock_system_stop, core_run_enable, sup}, 8'hbf)
			rd_chk(32'hc, 16'h0009);
			mode(3);
		end
		close_out();
	end
endmodule
bind sleep_power_planning_control power_plan_props u_props (.*);
`default_nettype wire
